// ==== hw/ssp_ctrl.sv ====
// Serial port control: APB registers, SPI and I2C host and client
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`include "ssp_cfg.svh"
module ssp_ctrl
  import ssp_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        timer_two_output_i,
  input  wire logic        serial_clock_pin_i,
  input  wire logic        serial_in_pin_i,
  input  wire logic        client_select_pin_n_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output ssp_pin_t         serial_clock_pin_o,
  output ssp_pin_t         serial_out_pin_o,
  output ssp_pin_t         scl_o,
  output ssp_pin_t         sda_o,
  output logic             port_active_o,
  output logic             cond_event_o
);
  logic        en_ff, ckp_ff, ovf_ff, general_call_enable_ff, ack_received_status_ff, ack_value_to_send_ff;
  ssp_mode_t   mode_ff;
  logic [7:0]  baud_ff, buf_ff, sh_ff, cl_sh_ff, cl_tx_ff;
  logic        bf_ff, host_rx_ff, cl_rx_ff, scl_hold_ff, ack_drv_ff;
  logic        addressed_ff, prev_sck_ff, prev_scl_ff, prev_sda_ff;
  logic        cond_ev_ff;
  ssp_seq_t    seq_ff;
  logic [5:0]  ph_ff;
  logic [3:0]  cl_cnt_ff;
  logic [9:0]  tick_cnt_ff, tick_rel;
  logic [31:0] prdata_ff;
  ssp_pin_t    sck_ff, sdo_ff, scl_ff, sda_ff;
  logic        hit_a, hit_b, hit_buf, hit_baud, hit_stat, hit_any;
  logic        wr, wr_a, wr_b, wr_buf, wr_baud, rd_buf;
  logic        spi_host, spi_cli, i2c_host, i2c_cli, busy, tick;
  logic        scl_low_h, sda_low_h, seq_last, cl_sel, match;
  logic [7:0]  rd_val, ctrl_a_val, ctrl_b_val;

  // Mode classes, all gated by the enable bit
  always_comb begin
    spi_host = en_ff && (mode_ff inside {SSP_SPI_H_DIV4, SSP_SPI_H_DIV16,
               SSP_SPI_H_DIV64, SSP_SPI_H_TMR, SSP_SPI_H_BAUD});
    spi_cli  = en_ff && (mode_ff inside {SSP_SPI_C_SEL, SSP_SPI_C_FREE});
    i2c_host = en_ff && (mode_ff inside {SSP_I2C_H, SSP_I2C_FW});
    i2c_cli  = en_ff && (mode_ff inside {SSP_I2C_C7, SSP_I2C_C10,
               SSP_I2C_C7_EV, SSP_I2C_C10_EV});
    busy     = (seq_ff != SSP_SEQ_IDLE);
  end

  // Address decode; each register owns one aligned word
  always_comb begin
    hit_a = 1'b0; hit_b = 1'b0; hit_buf = 1'b0;
    hit_baud = 1'b0; hit_stat = 1'b0;
    if (paddr_i == {`SSP_IDX_CTRL_A, 2'b00}) hit_a = 1'b1;
    else if (paddr_i == {`SSP_IDX_CTRL_B, 2'b00}) hit_b = 1'b1;
    else if (paddr_i == {`SSP_IDX_BUF, 2'b00}) hit_buf = 1'b1;
    else if (paddr_i == {`SSP_IDX_BAUD, 2'b00}) hit_baud = 1'b1;
    else if (paddr_i == {`SSP_IDX_STAT, 2'b00}) hit_stat = 1'b1;
    hit_any = hit_a | hit_b | hit_buf | hit_baud | hit_stat;
    wr      = psel_i && penable_i && pwrite_i && pstrb_i[0];
    wr_a    = wr && hit_a;
    wr_b    = wr && hit_b;
    wr_buf  = wr && hit_buf;
    wr_baud = wr && hit_baud;
    rd_buf  = psel_i && penable_i && !pwrite_i && hit_buf;
  end

  // Zero wait states; unmapped words answer with an error
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !hit_any;
  assign prdata_o  = prdata_ff;

  // Trigger bits read back as the sequence in flight
  always_comb begin
    ctrl_a_val = {1'b0, ovf_ff, en_ff, ckp_ff, mode_ff};
    ctrl_b_val = {general_call_enable_ff, ack_received_status_ff, ack_value_to_send_ff,
                  seq_ff == SSP_SEQ_ACK, seq_ff == SSP_SEQ_RECV,
                  seq_ff == SSP_SEQ_STOP, seq_ff == SSP_SEQ_RSTRT,
                  seq_ff == SSP_SEQ_START};
    rd_val = 8'h00;
    if (hit_a) rd_val = ctrl_a_val;
    else if (hit_b) rd_val = ctrl_b_val;
    else if (hit_buf) rd_val = buf_ff;
    else if (hit_baud) rd_val = baud_ff;
    else if (hit_stat) rd_val = {6'h00, busy, bf_ff};
  end

  // Read data captured in the setup cycle, held for the access
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) prdata_ff <= 32'h0000_0000;
    else if (psel_i && !penable_i) prdata_ff <= {24'h00_0000, rd_val};
  end

  // Control A and B plain fields and the divider
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      en_ff    <= 1'b0;
      ckp_ff   <= 1'b0;
      mode_ff  <= ssp_mode_t'(4'(`SSP_RST_CTRL));
      general_call_enable_ff  <= 1'b0;
      ack_value_to_send_ff <= 1'b0;
      baud_ff  <= `SSP_RST_BAUD;
    end else begin
      if (wr_a) begin
        en_ff   <= pwdata_i[`SSP_A_EN];
        ckp_ff  <= pwdata_i[`SSP_A_CKP];
        mode_ff <= ssp_mode_t'(pwdata_i[3:0]);
      end
      if (wr_b) begin
        general_call_enable_ff  <= pwdata_i[`SSP_B_GENERAL_CALL_ENABLE];
        ack_value_to_send_ff <= pwdata_i[`SSP_B_ACK_VALUE_TO_SEND];
      end
      if (wr_baud) baud_ff <= pwdata_i[7:0];
    end
  end

  // Half or quarter bit period, in oscillator cycles minus one
  always_comb begin
    case (mode_ff)
      SSP_SPI_H_DIV4:  tick_rel = 10'(`SSP_SYSTEM_OSCILLATOR_FREQ_DIV4 / 2 - 1);
      SSP_SPI_H_DIV16: tick_rel = 10'(`SSP_SYSTEM_OSCILLATOR_FREQ_DIV16 / 2 - 1);
      SSP_SPI_H_DIV64: tick_rel = 10'(`SSP_SYSTEM_OSCILLATOR_FREQ_DIV64 / 2 - 1);
      SSP_SPI_H_BAUD:  tick_rel = {1'b0, baud_ff, 1'b1};
      default:         tick_rel = {2'b00, baud_ff};
    endcase
  end

  // Period counter restarts whenever the sequencer rests
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) tick_cnt_ff <= 10'h000;
    else if (!busy || tick_cnt_ff == 10'h000) tick_cnt_ff <= tick_rel;
    else tick_cnt_ff <= tick_cnt_ff - 10'h001;
  end
  assign tick = (mode_ff == SSP_SPI_H_TMR) ? timer_two_output_i
                                           : (tick_cnt_ff == 10'h000);

  // I2C host line shapes per quarter of each phase
  always_comb begin
    scl_low_h = (ph_ff[1:0] == 2'd0) || (ph_ff[1:0] == 2'd3);
    sda_low_h = 1'b0;
    seq_last  = (ph_ff == 6'd3);
    case (seq_ff)
      SSP_SEQ_START: begin
        sda_low_h = (ph_ff != 6'd0);
        scl_low_h = (ph_ff >= 6'd2);
      end
      SSP_SEQ_RSTRT: begin
        sda_low_h = (ph_ff >= 6'd2);
      end
      SSP_SEQ_STOP: begin
        sda_low_h = (ph_ff <= 6'd1);
        scl_low_h = (ph_ff == 6'd0);
      end
      SSP_SEQ_ACK: sda_low_h = !ack_value_to_send_ff;
      SSP_SEQ_XMIT: begin
        sda_low_h = (ph_ff[5:2] < 4'd8) && !sh_ff[7];
        seq_last  = (ph_ff == 6'd35);
      end
      SSP_SEQ_RECV: seq_last = (ph_ff == 6'd31);
      SSP_SEQ_SPI:  seq_last = (ph_ff == 6'd15);
      default: ;
    endcase
  end

  // Host sequencer; one launch at a time, nothing queued
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !en_ff) begin
      seq_ff      <= SSP_SEQ_IDLE;
      ph_ff       <= 6'd0;
      sh_ff       <= 8'h00;
      ack_received_status_ff  <= 1'b0;
      host_rx_ff  <= 1'b0;
      scl_hold_ff <= 1'b0;
    end else begin
      host_rx_ff <= 1'b0;
      if (seq_ff == SSP_SEQ_IDLE) begin
        ph_ff <= 6'd0;
        if (wr_buf && (spi_host || i2c_host)) begin
          sh_ff  <= pwdata_i[7:0];
          seq_ff <= spi_host ? SSP_SEQ_SPI : SSP_SEQ_XMIT;
        end else if (wr_b && i2c_host) begin
          if (pwdata_i[`SSP_B_SEN]) seq_ff <= SSP_SEQ_START;
          else if (pwdata_i[`SSP_B_RESTART_SEQUENCE_START]) seq_ff <= SSP_SEQ_RSTRT;
          else if (pwdata_i[`SSP_B_PEN]) seq_ff <= SSP_SEQ_STOP;
          else if (pwdata_i[`SSP_B_ACK_SEQUENCE_START]) seq_ff <= SSP_SEQ_ACK;
          else if (pwdata_i[`SSP_B_HOST_RECEIVE_ENABLE]) seq_ff <= SSP_SEQ_RECV;
        end
      end else if (tick) begin
        ph_ff <= ph_ff + 6'd1;
        if (seq_ff == SSP_SEQ_SPI && ph_ff[0])
          sh_ff <= {sh_ff[6:0], serial_in_pin_i};
        if (seq_ff == SSP_SEQ_XMIT && ph_ff == 6'd34)
          ack_received_status_ff <= sda_i;
        if (seq_ff == SSP_SEQ_XMIT && ph_ff[1:0] == 2'd3)
          sh_ff <= {sh_ff[6:0], 1'b0};
        if (seq_ff == SSP_SEQ_RECV && ph_ff[1:0] == 2'd2)
          sh_ff <= {sh_ff[6:0], sda_i};
        if (seq_last) begin
          seq_ff     <= SSP_SEQ_IDLE;
          host_rx_ff <= (seq_ff == SSP_SEQ_RECV) ||
                        (seq_ff == SSP_SEQ_SPI);
          scl_hold_ff <= (seq_ff != SSP_SEQ_STOP) &&
                         (seq_ff != SSP_SEQ_SPI);
        end
      end
    end
  end

  // Client address match, own address kept in the divider
  always_comb begin
    if (mode_ff == SSP_I2C_C10 || mode_ff == SSP_I2C_C10_EV)
      match = (cl_sh_ff[7:3] == 5'b11110) &&
              (cl_sh_ff[2:1] == baud_ff[2:1]);
    else
      match = (cl_sh_ff[7:1] == baud_ff[7:1]);
    match = match || (general_call_enable_ff && cl_sh_ff == 8'h00);
  end
  assign cl_sel = (mode_ff == SSP_SPI_C_FREE) || !client_select_pin_n_i;

  // Client receivers; inputs arrive synchronous to the clock
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !en_ff) begin
      cl_sh_ff     <= 8'h00;
      cl_cnt_ff    <= 4'd0;
      cl_rx_ff     <= 1'b0;
      cl_tx_ff     <= 8'h00;
      ack_drv_ff   <= 1'b0;
      addressed_ff <= 1'b0;
      cond_ev_ff   <= 1'b0;
      prev_sck_ff  <= 1'b0;
      prev_scl_ff  <= 1'b1;
      prev_sda_ff  <= 1'b1;
    end else begin
      prev_sck_ff <= serial_clock_pin_i;
      prev_scl_ff <= scl_i;
      prev_sda_ff <= sda_i;
      cl_rx_ff    <= 1'b0;
      cond_ev_ff  <= 1'b0;
      if (wr_buf && spi_cli) cl_tx_ff <= pwdata_i[7:0];
      if (spi_cli) begin
        if (!cl_sel) cl_cnt_ff <= 4'd0;
        else if (prev_sck_ff == ckp_ff && serial_clock_pin_i != ckp_ff)
        begin
          cl_sh_ff  <= {cl_sh_ff[6:0], serial_in_pin_i};
          cl_cnt_ff <= (cl_cnt_ff == 4'd7) ? 4'd0 : cl_cnt_ff + 4'd1;
          cl_rx_ff  <= (cl_cnt_ff == 4'd7);
        end else if (prev_sck_ff != ckp_ff &&
                     serial_clock_pin_i == ckp_ff)
          cl_tx_ff <= {cl_tx_ff[6:0], 1'b0};
      end else if (i2c_cli) begin
        if (prev_scl_ff && scl_i && prev_sda_ff != sda_i) begin
          // Start or stop resets the byte framing
          cl_cnt_ff    <= 4'd0;
          addressed_ff <= 1'b0;
          ack_drv_ff   <= 1'b0;
          cond_ev_ff   <= (mode_ff == SSP_I2C_C7_EV) ||
                          (mode_ff == SSP_I2C_C10_EV);
        end else if (!prev_scl_ff && scl_i && cl_cnt_ff < 4'd8) begin
          cl_sh_ff  <= {cl_sh_ff[6:0], sda_i};
          cl_cnt_ff <= cl_cnt_ff + 4'd1;
        end else if (prev_scl_ff && !scl_i) begin
          if (cl_cnt_ff == 4'd8) begin
            cl_cnt_ff <= 4'd9;
            if (!addressed_ff) begin
              ack_drv_ff   <= match;
              addressed_ff <= match;
            end else begin
              ack_drv_ff <= 1'b1;
              cl_rx_ff   <= 1'b1;
            end
          end else if (cl_cnt_ff == 4'd9) begin
            cl_cnt_ff  <= 4'd0;
            ack_drv_ff <= 1'b0;
          end
        end
      end
    end
  end

  // Shift data buffer, full flag and overrun flag
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      buf_ff <= 8'h00;
      bf_ff  <= 1'b0;
      ovf_ff <= 1'b0;
    end else begin
      // Set wins over a software clear in the same cycle
      if (cl_rx_ff && bf_ff && (spi_cli || i2c_cli))
        ovf_ff <= 1'b1;
      else if (wr_a)
        ovf_ff <= pwdata_i[`SSP_A_OVF];
      if (!en_ff)
        bf_ff <= 1'b0;
      else if (host_rx_ff) begin
        buf_ff <= sh_ff;
        bf_ff  <= 1'b1;
      end else if (cl_rx_ff && !bf_ff) begin
        buf_ff <= cl_sh_ff;
        bf_ff  <= 1'b1;
      end else if (cl_rx_ff) begin
        // Full buffer keeps the unread byte
        bf_ff <= 1'b1;
      end else begin
        if (rd_buf) bf_ff <= 1'b0;
        if (wr_buf && !busy) buf_ff <= pwdata_i[7:0];
      end
    end
  end

  // Pin drives, registered; all enables drop when disabled
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sck_ff <= '0;
      sdo_ff <= '0;
      scl_ff <= '0;
      sda_ff <= '0;
    end else begin
      sck_ff.out <= ckp_ff ^ (seq_ff == SSP_SEQ_SPI && ph_ff[0]);
      sck_ff.oe  <= spi_host;
      sdo_ff.out <= spi_host ? sh_ff[7] : cl_tx_ff[7];
      sdo_ff.oe  <= spi_host || (spi_cli && cl_sel);
      scl_ff.out <= 1'b0;
      scl_ff.oe  <= (i2c_cli && !ckp_ff) ||
                    (i2c_host && (busy ? scl_low_h : scl_hold_ff));
      sda_ff.out <= 1'b0;
      sda_ff.oe  <= (i2c_host && busy && sda_low_h) ||
                    (i2c_cli && ack_drv_ff);
    end
  end

  assign serial_clock_pin_o = sck_ff;
  assign serial_out_pin_o   = sdo_ff;
  assign scl_o              = scl_ff;
  assign sda_o              = sda_ff;
  assign port_active_o      = en_ff;
  assign cond_event_o       = cond_ev_ff;

  // Checks on the control behaviour
  AST_OVF_SET: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    cl_rx_ff && bf_ff && (spi_cli || i2c_cli) |=> ovf_ff)
    else $error("overrun not raised on full buffer");
  AST_HOST_NO_OVF: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    (spi_host || i2c_host) && !ovf_ff && !wr_a |=> !ovf_ff)
    else $error("overrun raised in host mode");
  AST_PINS_FREE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !en_ff ##1 !en_ff |-> !sck_ff.oe && !sdo_ff.oe && !scl_ff.oe
    && !sda_ff.oe)
    else $error("pin driven while port disabled");
  AST_IDLE_CLK: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    spi_host && !busy |=> sck_ff.oe && sck_ff.out == $past(ckp_ff))
    else $error("idle clock level wrong");
  AST_STRETCH: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    i2c_cli && !ckp_ff |=> scl_ff.oe && !scl_ff.out)
    else $error("client clock not stretched");
  // Age of a start sequence; a counter keeps the bound cheap to check
  logic [10:0] start_age_ff;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || seq_ff != SSP_SEQ_START) start_age_ff <= 11'h000;
    else if (start_age_ff != 11'h7FF) start_age_ff <= start_age_ff + 11'h001;
  end
  AST_START_DONE: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    start_age_ff <= `SSP_START_MAX)
    else $error("start bit not cleared");
  AST_BUSY_LOCK: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    busy && wr_buf && !host_rx_ff && !cl_rx_ff && en_ff |=> $stable(buf_ff)
    && seq_ff == $past(seq_ff) || seq_ff == SSP_SEQ_IDLE)
    else $error("buffer written while busy");
  AST_ACK_STAT: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    en_ff && seq_ff == SSP_SEQ_XMIT && tick && ph_ff == 6'd34
    |=> ack_received_status_ff == $past(sda_i) ##1 seq_ff != SSP_SEQ_IDLE
    || ph_ff == 6'd35)
    else $error("ack status not recorded");
  AST_SEL_GATE: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    spi_cli && mode_ff == SSP_SPI_C_SEL && client_select_pin_n_i
    |=> cl_cnt_ff == 4'd0 && !cl_rx_ff)
    else $error("deselected client still counting");
endmodule : ssp_ctrl

// ==== shared/ssp_cfg.svh ====
// Register map, field positions, reset values and clock divides
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// Register indexes; byte address is four times the index
`define SSP_IDX_CTRL_A   10'h190
`define SSP_IDX_CTRL_B   10'h191
`define SSP_IDX_BUF      10'h18C
`define SSP_IDX_BAUD     10'h18D
`define SSP_IDX_STAT     10'h18E

// Control A fields
`define SSP_A_OVF        6
`define SSP_A_EN         5
`define SSP_A_CKP        4
// Control B fields
`define SSP_B_GENERAL_CALL_ENABLE       7
`define SSP_B_ACK_RECEIVED_STATUS    6
`define SSP_B_ACK_VALUE_TO_SEND      5
`define SSP_B_ACK_SEQUENCE_START      4
`define SSP_B_HOST_RECEIVE_ENABLE       3
`define SSP_B_PEN        2
`define SSP_B_RESTART_SEQUENCE_START       1
`define SSP_B_SEN        0
// Status fields
`define SSP_S_BF         0
`define SSP_S_BUSY       1

// Reset values
`define SSP_RST_CTRL     8'h00
`define SSP_RST_BAUD     8'h00

// Oscillator divides of the fixed SPI host rates
`define SSP_SYSTEM_OSCILLATOR_FREQ_DIV4    4
`define SSP_SYSTEM_OSCILLATOR_FREQ_DIV16   16
`define SSP_SYSTEM_OSCILLATOR_FREQ_DIV64   64
// Longest start sequence, four quarters at the widest divider, plus margin
`define SSP_START_MAX    11'h406
`endif

// ==== shared/ssp_pkg.sv ====
// Types shared by the serial port control block
package ssp_pkg;
  // Port mode codes
  typedef enum logic [3:0] {
    SSP_SPI_H_DIV4  = 4'h0,
    SSP_SPI_H_DIV16 = 4'h1,
    SSP_SPI_H_DIV64 = 4'h2,
    SSP_SPI_H_TMR   = 4'h3,
    SSP_SPI_C_SEL   = 4'h4,
    SSP_SPI_C_FREE  = 4'h5,
    SSP_I2C_C7      = 4'h6,
    SSP_I2C_C10     = 4'h7,
    SSP_I2C_H       = 4'h8,
    SSP_RSV_9       = 4'h9,
    SSP_SPI_H_BAUD  = 4'hA,
    SSP_I2C_FW      = 4'hB,
    SSP_RSV_C       = 4'hC,
    SSP_RSV_D       = 4'hD,
    SSP_I2C_C7_EV   = 4'hE,
    SSP_I2C_C10_EV  = 4'hF
  } ssp_mode_t;
  // Host sequencer states, Gray along start, send, receive, ack, stop
  typedef enum logic [2:0] {
    SSP_SEQ_IDLE  = 3'b000,
    SSP_SEQ_START = 3'b001,
    SSP_SEQ_XMIT  = 3'b011,
    SSP_SEQ_RECV  = 3'b010,
    SSP_SEQ_ACK   = 3'b110,
    SSP_SEQ_STOP  = 3'b111,
    SSP_SEQ_RSTRT = 3'b101,
    SSP_SEQ_SPI   = 3'b100
  } ssp_seq_t;
  // One pin drive: level and output enable
  typedef struct packed {
    logic out;
    logic oe;
  } ssp_pin_t;
endpackage : ssp_pkg

// ==== dv/ssp_bus_model.sv ====
// Far-side I2C client model: pull-up wires and acknowledge drive
`timescale 1ns/10ps
module ssp_bus_model (
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic scl_pull_i,
  input  wire logic sda_pull_i,
  input  wire logic nack_i,
  output logic      scl_o,
  output logic      sda_o
);
  logic [3:0] rise_cnt_ff;
  logic       ack_drive_ff;
  logic       scl_q_ff;
  logic       sda_q_ff;

  // one shared wire each
  // Released wires float high through the pull-ups
  assign scl_o = ~scl_pull_i;
  assign sda_o = ~(sda_pull_i | ack_drive_ff);

  // Start resets bit count; ninth clock carries the answer
  always_ff @(posedge sys_clk_i) begin
    scl_q_ff <= scl_o;
    sda_q_ff <= sda_o;
    if (!rst_n_i || (scl_o && sda_q_ff && !sda_o)) begin
      rise_cnt_ff  <= 4'h0;
      ack_drive_ff <= 1'b0;
    end else if (!scl_q_ff && scl_o) begin
      rise_cnt_ff <= (rise_cnt_ff == 4'h9) ? 4'h1 : rise_cnt_ff + 4'h1;
    end else if (scl_q_ff && !scl_o) begin
      ack_drive_ff <= (rise_cnt_ff == 4'h8) && !nack_i;
    end
  end
endmodule : ssp_bus_model

// ==== dv/ssp_ctrl_tb_top.sv ====
// Self-checking bench of the serial port control block
`timescale 1ns/10ps
module ssp_ctrl_tb_top;
  import ssp_pkg::*;
  typedef struct {
    logic [31:0] d;
    logic [31:0] m;
    logic        e;
  } ssp_note_t;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic        tick    = 1'b0;
  logic        sck     = 1'b0;
  logic        sdi     = 1'b0;
  logic        lb      = 1'b1;
  logic        nack    = 1'b0;
  logic        ssn     = 1'b1;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, scl, sda, act;
  ssp_pin_t    sck_o, sdo_o, scl_o, sda_o;
  logic [7:0]  d1, d2;
  logic [3:0]  md [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hA};
  int          mismatches = 0;
  int          checked    = 0;
  int          seed       = 32'h266a;
  ssp_note_t   q [$];

  always #5 sys_clk = ~sys_clk;
  // Timer tick every other cycle
  always @(posedge sys_clk) tick <= ~tick;

  ssp_ctrl uut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .timer_two_output_i(tick),
    .serial_clock_pin_i(sck), .serial_in_pin_i(lb ? sdo_o.out : sdi),
    .client_select_pin_n_i(ssn), .scl_i(scl), .sda_i(sda),
    .serial_clock_pin_o(sck_o), .serial_out_pin_o(sdo_o), .scl_o(scl_o),
    .sda_o(sda_o), .port_active_o(act), .cond_event_o());

  ssp_bus_model partner (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
    .scl_pull_i(scl_o.oe), .sda_pull_i(sda_o.oe), .nack_i(nack),
    .scl_o(scl), .sda_o(sda));

  task chk(input string nm, input logic [31:0] got, input logic [31:0] ex);
    checked++;
    if (got !== ex) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task summarize;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  // One APB transfer; waits for pready under a bound
  task apb(input bit wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      summarize();
    end
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  // Note the expectation first; the monitor compares it
  task rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
          input bit e = 1'b0);
    q.push_back('{d, m, e});
    apb(1'b0, a, 32'h0);
  endtask : rd

  // Poll until the masked bits clear; running out is a failure
  task wt(input logic [11:0] a, input logic [31:0] m);
    int n;
    n = 0;
    repeat (2) @(posedge sys_clk);
    do begin
      rd(a, 32'h0, 32'h0);
      n++;
    end while ((prdata & m) !== 32'h0 && n < 2000);
    if (n >= 2000) begin
      mismatches++;
      summarize();
    end
  endtask : wt

  task sbyte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sdi <= b[i];
      repeat (4) @(posedge sys_clk);
      sck <= 1'b1;
      repeat (4) @(posedge sys_clk);
      sck <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
  endtask : sbyte

  // Read monitor: oldest note against the data of each read
  always @(posedge sys_clk) begin : mon
    ssp_note_t n;
    if (psel && penable && pready && !pwrite && q.size() > 0) begin
      n = q.pop_front();
      if (n.m != 32'h0) begin
        chk("prdata", prdata & n.m, n.d & n.m);
        chk("pslverr", {31'h0, pslverr}, {31'h0, n.e});
      end
    end
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(12'h640, 32'h0, 32'hFF);
    rd(12'h644, 32'h0, 32'hFF);
    rd(12'h7FC, 32'h0, 32'hFFFFFFFF, 1'b1);
    chk("active", {31'h0, act}, 32'h0);
    $display("test reset done");
    // every host clock choice, looped back
    wr(12'h634, 32'h1);
    foreach (md[i]) begin
      wr(12'h640, {24'h0, 4'h3, md[i]});
      repeat (3) @(posedge sys_clk);
      chk("active", {31'h0, act}, 32'h1);
      chk("sck idle", {31'h0, sck_o.out}, 32'h1);
      d1 = 8'($random(seed));
      d2 = 8'($random(seed));
      wr(12'h630, {24'h0, d1});
      wt(12'h638, 32'h2);
      wr(12'h630, {24'h0, d2});
      wt(12'h638, 32'h2);
      rd(12'h630, {24'h0, d2}, 32'hFF);
      rd(12'h640, 32'h0, 32'h40);
    end
    $display("test spi host done");
    // unread client byte overruns with select ignored, then select gates the client
    wr(12'h640, 32'h25);
    lb <= 1'b0;
    sbyte(d1);
    sbyte(d2);
    rd(12'h630, {24'h0, d1}, 32'hFF);
    rd(12'h640, 32'h65, 32'hFF);
    wr(12'h640, 32'h25);
    rd(12'h640, 32'h25, 32'hFF);
    wr(12'h640, 32'h24);
    sbyte(d1);
    rd(12'h638, 32'h0, 32'h1);
    ssn <= 1'b0;
    sbyte(d2);
    rd(12'h630, {24'h0, d2}, 32'hFF);
    rd(12'h640, 32'h24, 32'hFF);
    ssn <= 1'b1;
    $display("test spi client done");
    wr(12'h640, 32'h0);
    lb <= 1'b1;
    wr(12'h640, 32'h28);
    wr(12'h644, 32'h1);
    rd(12'h644, 32'h1, 32'h1);
    wt(12'h644, 32'h1);
    wr(12'h630, {24'h0, d1});
    wt(12'h638, 32'h2);
    rd(12'h644, 32'h0, 32'h40);
    nack <= 1'b1;
    wr(12'h644, 32'h2);
    wt(12'h644, 32'h2);
    wr(12'h630, {24'h0, d2});
    wt(12'h638, 32'h2);
    rd(12'h644, 32'h40, 32'h40);
    wr(12'h644, 32'h8);
    rd(12'h644, 32'h8, 32'h8);
    wt(12'h644, 32'h8);
    rd(12'h630, 32'hFF, 32'hFF);
    wr(12'h644, 32'h30);
    wt(12'h644, 32'h10);
    wr(12'h644, 32'h24);
    wt(12'h644, 32'h4);
    repeat (4) @(posedge sys_clk);
    chk("scl released", {31'h0, scl}, 32'h1);
    $display("test i2c host done");
    summarize();
  end
endmodule : ssp_ctrl_tb_top
